// ==== hw/external_pin_interrupt_unit.sv ====
// external pin interrupt unit: sense control, flags, masks, requests
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module external_pin_interrupt_unit (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // register port
   input wire ext_irq_pkg::reg_req_t reg_req_i,
   output logic [7:0] reg_rdata_o,
   // pins
   input wire logic ext_line_zero_i,
   input wire logic ext_line_one_i,
   input wire logic [23:0] pin_change_inputs_i,
   // core side
   input wire logic global_enable_i,
   input wire ext_irq_pkg::irq_vec_t ack_i,
   output ext_irq_pkg::irq_vec_t irq_o
);
   import ext_irq_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] sense_ctl;
   logic [1:0] line_en;
   logic [1:0] line_flag;
   logic [2:0] grp_en;
   logic [2:0] grp_flag;
   logic [23:0] pin_mask;
   logic [1:0] line_prev;
   logic [23:0] pin_prev;
   logic prim_done;

   // register selects
   wire wr_sense = reg_req_i.wr && reg_req_i.addr == SENSE_OFS;
   wire wr_line_en = reg_req_i.wr && reg_req_i.addr == LINE_EN_OFS;
   wire wr_line_flag = reg_req_i.wr && reg_req_i.addr == LINE_FLAG_OFS;
   wire wr_grp_en = reg_req_i.wr && reg_req_i.addr == GRP_EN_OFS;
   wire wr_grp_flag = reg_req_i.wr && reg_req_i.addr == GRP_FLAG_OFS;
   wire wr_mask0 = reg_req_i.wr && reg_req_i.addr == MASK0_OFS;
   wire wr_mask1 = reg_req_i.wr && reg_req_i.addr == MASK1_OFS;
   wire wr_mask2 = reg_req_i.wr && reg_req_i.addr == MASK2_OFS;

   ////////////////////////////////////////////////////////////////////
   // sense decode shared by both lines
   function automatic logic edge_hit(input logic [1:0] mode,
                                     input logic prev, input logic now);
      logic hit;
      hit = 1'b0;
      unique case (sense_mode_t'(mode))
         SENSE_LOW: hit = 1'b0;
         SENSE_ANY: hit = prev ^ now;
         SENSE_FALL: hit = prev & ~now;
         SENSE_RISE: hit = ~prev & now;
      endcase
      return hit;
   endfunction : edge_hit

   wire [1:0] mode_one = sense_ctl[SENSE_ONE_LSB +: 2];
   wire [1:0] mode_zero = sense_ctl[SENSE_ZERO_LSB +: 2];
   wire [1:0] line_now = {ext_line_one_i, ext_line_zero_i};
   wire [1:0] line_is_level = {mode_one == SENSE_LOW, mode_zero == SENSE_LOW};
   // pins are seen as inputs whatever their direction, so software may
   // raise interrupts by driving them
   // edges come from the sampled previous value against the pin
   wire [1:0] line_edge = {
      edge_hit(mode_one, line_prev[1], line_now[1]),
      edge_hit(mode_zero, line_prev[0], line_now[0])};
   // level requests are combinational on the pin, then registered into irq_o on the clock
   // the source must hold the level long enough to be taken
   wire [1:0] line_level_req = line_is_level & ~line_now;

   ////////////////////////////////////////////////////////////////////
   // pin change detection, masked per pin
   wire [23:0] pin_hit = (pin_prev ^ pin_change_inputs_i) & pin_mask;
   // one change detector per group, each folding its masked pins, seven in group one and eight in the others
   logic [2:0] grp_hit;
   for (genvar g = 0; g < 3; g++) begin : g_group
      assign grp_hit[g] = |pin_hit[g * 8 +: 8];
   end

   ////////////////////////////////////////////////////////////////////
   // flag next values: a set wins over ack or write-one clear
   wire [1:0] line_clr = ({2{wr_line_flag}} & reg_req_i.wdata[1:0]) |
                         {ack_i.line_one, ack_i.line_zero};
   wire [2:0] grp_clr = ({3{wr_grp_flag}} & reg_req_i.wdata[2:0]) |
                        ack_i.group;
   wire [1:0] line_set = prim_done ? line_edge & ~line_is_level : 2'b00;
   wire [2:0] grp_set = prim_done ? grp_hit & grp_en : 3'b000;
   // level mode keeps the flag cleared
   wire [1:0] next_line_flag =
      ((line_flag & ~line_clr) | line_set) & ~line_is_level;
   wire [2:0] next_grp_flag = (grp_flag & ~grp_clr) | grp_set;

   ////////////////////////////////////////////////////////////////////
   // requests toward the core, gated by line/group and global enable
   // a flag left over from edge mode must not request once level is chosen
   wire [1:0] line_src = (line_flag & ~line_is_level) | line_level_req;
   wire [1:0] next_line_irq = line_src & line_en & {2{global_enable_i}};
   // a masked pin without its group enable raises nothing
   wire [2:0] next_grp_irq = grp_flag & grp_en & {3{global_enable_i}};

   ////////////////////////////////////////////////////////////////////
   // read mux, unused bits read zero
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (reg_req_i.addr)
         SENSE_OFS: next_rdata = sense_ctl & SENSE_BITS;
         LINE_EN_OFS: next_rdata = {6'h00, line_en};
         LINE_FLAG_OFS: next_rdata = {6'h00, line_flag & ~line_is_level};
         GRP_EN_OFS: next_rdata = {5'h00, grp_en};
         GRP_FLAG_OFS: next_rdata = {5'h00, grp_flag};
         MASK0_OFS: next_rdata = pin_mask[7:0];
         MASK1_OFS: next_rdata = pin_mask[15:8] & MASK1_BITS;
         MASK2_OFS: next_rdata = pin_mask[23:16];
         default: next_rdata = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // control registers, all zero at reset
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sense_ctl <= REG_RESET;
         line_en <= 2'b00;
         grp_en <= 3'b000;
         pin_mask <= 24'h000000;
      end else begin
         if (wr_sense) sense_ctl <= reg_req_i.wdata & SENSE_BITS;
         if (wr_line_en) line_en <= reg_req_i.wdata[1:0];
         if (wr_grp_en) grp_en <= reg_req_i.wdata[2:0];
         if (wr_mask0) pin_mask[7:0] <= reg_req_i.wdata & MASK_FULL;
         if (wr_mask1) pin_mask[15:8] <= reg_req_i.wdata & MASK1_BITS;
         if (wr_mask2) pin_mask[23:16] <= reg_req_i.wdata;
      end
   end

   // samples and flags; prim_done blocks a false edge right after reset
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_prev <= 2'b00;
         pin_prev <= 24'h000000;
         prim_done <= 1'b0;
         line_flag <= 2'b00;
         grp_flag <= 3'b000;
      end else begin
         line_prev <= line_now;
         pin_prev <= pin_change_inputs_i;
         prim_done <= 1'b1;
         line_flag <= next_line_flag;
         grp_flag <= next_grp_flag;
      end
   end

   // registered outputs, one request line per vector
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= '0;
         reg_rdata_o <= 8'h00;
      end else begin
         irq_o <= {next_grp_irq, next_line_irq};
         reg_rdata_o <= reg_req_i.rd ? next_rdata : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   property p_level_req;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (line_is_level[0] && !ext_line_zero_i && line_en[0] && global_enable_i)
         |=> irq_o.line_zero;
   endproperty
   a_level_req: assert property (p_level_req)
      else $error("level request on line zero missing");

   property p_level_flag;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      line_is_level[1] |=> !line_flag[1];
   endproperty
   a_level_flag: assert property (p_level_flag)
      else $error("line one flag set in level mode");

   property p_fall_sets;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && mode_zero == SENSE_FALL && line_prev[0]
       && !ext_line_zero_i) |=> line_flag[0];
   endproperty
   a_fall_sets: assert property (p_fall_sets)
      else $error("falling edge did not set line zero flag");

   property p_rise_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && mode_one == SENSE_RISE && !line_prev[1]
       && ext_line_one_i) |=> line_flag[1];
   endproperty
   a_rise_one: assert property (p_rise_one)
      else $error("rising edge did not set line one flag");

   property p_gate_global;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !global_enable_i |=> irq_o == '0;
   endproperty
   a_gate_global: assert property (p_gate_global)
      else $error("request without global enable");

   property p_grp_gate;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !grp_en[2] |=> !irq_o.group[2];
   endproperty
   a_grp_gate: assert property (p_grp_gate)
      else $error("group two request while disabled");

   property p_pin_sets;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && grp_en[2] && |pin_hit[23:16]) |=> grp_flag[2];
   endproperty
   a_pin_sets: assert property (p_pin_sets)
      else $error("pin change did not set group two flag");

   property p_masked;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (pin_mask[7:0] == 8'h00 && !grp_flag[0]
       && !(wr_mask0)) |=> !grp_flag[0];
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked pins set group zero flag");

   property p_ack_clear;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ack_i.group[1] && !grp_set[1]) |=> !grp_flag[1];
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("ack did not clear group one flag");

   property p_reserved;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_req_i.rd && reg_req_i.addr == GRP_FLAG_OFS)
         |=> reg_rdata_o[7:3] == 5'h00;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits read nonzero");

   property p_level_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (line_is_level[1] && !ext_line_one_i && line_en[1] && global_enable_i)
         |=> irq_o.line_one;
   endproperty
   a_level_one: assert property (p_level_one)
      else $error("level request on line one missing");

   property p_any_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && mode_zero == SENSE_ANY
       && line_prev[0] != ext_line_zero_i) |=> line_flag[0];
   endproperty
   a_any_zero: assert property (p_any_zero)
      else $error("change did not set line zero flag");

   property p_fall_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && mode_one == SENSE_FALL && line_prev[1]
       && !ext_line_one_i) |=> line_flag[1];
   endproperty
   a_fall_one: assert property (p_fall_one)
      else $error("falling edge did not set line one flag");

   property p_low_zero_flag;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      line_is_level[0] |=> !line_flag[0];
   endproperty
   a_low_zero_flag: assert property (p_low_zero_flag)
      else $error("line zero flag set in level mode");

   property p_en_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !line_en[0] |=> !irq_o.line_zero;
   endproperty
   a_en_zero: assert property (p_en_zero)
      else $error("line zero request while disabled");

   property p_en_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !line_en[1] |=> !irq_o.line_one;
   endproperty
   a_en_one: assert property (p_en_one)
      else $error("line one request while disabled");

   property p_flag_one_req;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (line_flag[1] && !line_is_level[1] && line_en[1] && global_enable_i)
         |=> irq_o.line_one;
   endproperty
   a_flag_one_req: assert property (p_flag_one_req)
      else $error("line one flag did not request");

   property p_grp_req;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (grp_flag[0] && grp_en[0] && global_enable_i) |=> irq_o.group[0];
   endproperty
   a_grp_req: assert property (p_grp_req)
      else $error("group zero flag did not request");

   property p_w1c_line;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_line_flag && reg_req_i.wdata[0] && !line_set[0])
         |=> !line_flag[0];
   endproperty
   a_w1c_line: assert property (p_w1c_line)
      else $error("write one did not clear line zero flag");

   property p_w1c_grp;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (wr_grp_flag && reg_req_i.wdata[2] && !grp_set[2])
         |=> !grp_flag[2];
   endproperty
   a_w1c_grp: assert property (p_w1c_grp)
      else $error("write one did not clear group two flag");

   property p_ack_own;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (ack_i.line_zero && !ack_i.line_one && !wr_line_flag && line_flag[1]
       && !line_is_level[1]) |=> line_flag[1];
   endproperty
   a_ack_own: assert property (p_ack_own)
      else $error("ack of line zero cleared line one flag");

   property p_grp_off;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (!grp_en[1] && !grp_flag[1]) |=> !grp_flag[1];
   endproperty
   a_grp_off: assert property (p_grp_off)
      else $error("disabled group one set its flag");

   property p_mask1_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_req_i.rd && reg_req_i.addr == MASK1_OFS)
         |=> !reg_rdata_o[7];
   endproperty
   a_mask1_read: assert property (p_mask1_read)
      else $error("reserved group one mask bit read nonzero");

   property p_rdata_idle;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !reg_req_i.rd |=> reg_rdata_o == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data nonzero without a read");

   property p_sense_read;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (reg_req_i.rd && reg_req_i.addr == SENSE_OFS)
         |=> reg_rdata_o[7:4] == 4'h0;
   endproperty
   a_sense_read: assert property (p_sense_read)
      else $error("reserved sense bits read nonzero");

   property p_pin_grp_zero;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && grp_en[0] && |pin_hit[7:0]) |=> grp_flag[0];
   endproperty
   a_pin_grp_zero: assert property (p_pin_grp_zero)
      else $error("pin change did not set group zero flag");

   property p_pin_grp_one;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (prim_done && grp_en[1] && |pin_hit[15:8]) |=> grp_flag[1];
   endproperty
   a_pin_grp_one: assert property (p_pin_grp_one)
      else $error("pin change did not set group one flag");

   c_level: cover property (@(posedge core_clk_i) irq_o.line_zero);
   c_edge: cover property (@(posedge core_clk_i) $rose(line_flag[1]));
   c_group: cover property (@(posedge core_clk_i) irq_o.group[2]);
   c_w1c: cover property (@(posedge core_clk_i)
      wr_grp_flag && grp_flag != 3'b000);
endmodule : external_pin_interrupt_unit

// ==== hw/ext_irq_pkg.sv ====
// constants, register map and types of the external pin interrupt unit
package ext_irq_pkg;
   // register offsets (byte addresses on the plain port)
   localparam logic [3:0] SENSE_OFS = 4'h0;
   localparam logic [3:0] LINE_EN_OFS = 4'h1;
   localparam logic [3:0] LINE_FLAG_OFS = 4'h2;
   localparam logic [3:0] GRP_EN_OFS = 4'h3;
   localparam logic [3:0] GRP_FLAG_OFS = 4'h4;
   localparam logic [3:0] MASK0_OFS = 4'h5;
   localparam logic [3:0] MASK1_OFS = 4'h6;
   localparam logic [3:0] MASK2_OFS = 4'h7;
   // field positions
   localparam int SENSE_ONE_LSB = 2;
   localparam int SENSE_ZERO_LSB = 0;
   // reset values and implemented-bit masks
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] SENSE_BITS = 8'h0F;
   localparam logic [7:0] LINE_BITS = 8'h03;
   localparam logic [7:0] GRP_BITS = 8'h07;
   localparam logic [7:0] MASK1_BITS = 8'h7F;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   // sense modes
   typedef enum logic [1:0] {
      SENSE_LOW = 2'b00,
      SENSE_ANY = 2'b01,
      SENSE_FALL = 2'b10,
      SENSE_RISE = 2'b11
   } sense_mode_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // vector requests toward the core
   typedef struct packed {
      logic [2:0] group;
      logic line_one;
      logic line_zero;
   } irq_vec_t;
endpackage : ext_irq_pkg

// ==== sim/core_ack_model.sv ====
// core model: takes a pending vector and pulses its handler-entry ack
`timescale 1ns/1ps
module core_ack_model (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   // requests and control
   input wire ext_irq_pkg::irq_vec_t irq_i,
   input wire logic ack_on_i,
   // handler entry
   output ext_irq_pkg::irq_vec_t ack_o
);
   import ext_irq_pkg::*;
   logic [2:0] hold;
   logic [4:0] pend;
   ////////////////////////////////////////////////////////////////////////
   // lowest vector wins; holdoff stops a second ack while the request drains
   assign pend = irq_i;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_o <= '0;
         hold <= 3'h0;
      end else begin
         ack_o <= '0;
         if (hold != 3'h0) begin
            hold <= hold - 3'h1;
         end else if (ack_on_i && pend != 5'h00) begin
            ack_o <= irq_vec_t'(pend & (~pend + 5'h01));
            hold <= 3'h4;
         end
      end
   end
endmodule : core_ack_model

// ==== sim/testbench.sv ====
// self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
   n_mismatch++; $display("BAD %0t got %h exp %h", $time, got, exp); end end
module testbench;
   import ext_irq_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   reg_req_t req = '0;
   logic [7:0] rdata;
   logic line0 = 1'b1;
   logic line1 = 1'b1;
   logic gie = 1'b0;
   logic ack_on = 1'b0;
   logic [23:0] pins = 24'h000000;
   irq_vec_t ack;
   irq_vec_t irq;
   int n_mismatch = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////////////
   // design and core model
   external_pin_interrupt_unit i_external_pin_interrupt_unit (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .ext_line_zero_i(line0), .ext_line_one_i(line1),
      .pin_change_inputs_i(pins), .global_enable_i(gie), .ack_i(ack),
      .irq_o(irq));
   core_ack_model i_core_ack_model (
      .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .irq_i(irq),
      .ack_on_i(ack_on), .ack_o(ack));
   // 25 MHz clock
   initial begin
      forever #20 core_clk_i = ~core_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   // settle: checks land mid-cycle so registered outputs are stable
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask : settle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      req.rd <= 1'b0;
      @(negedge core_clk_i);
      `CHK(rdata, e)
   endtask : rd
   function automatic logic hit(input logic [1:0] md, input logic fall);
      return md == SENSE_ANY || md == (fall ? SENSE_FALL : SENSE_RISE);
   endfunction : hit
   ////////////////////////////////////////////////////////////////////////
   // every offset, unmapped ones too, reads zero after reset
   task automatic t_reset;
      for (int a = 0; a < 16; a++) rd(a[3:0], REG_RESET);
   endtask : t_reset
   task automatic t_reserved;
      logic [7:0] m [8];
      m = '{SENSE_BITS, LINE_BITS, 8'h00, GRP_BITS, 8'h00, MASK_FULL,
            MASK1_BITS, MASK_FULL};
      for (int a = 0; a < 9; a++) wr(a[3:0], 8'hFF);
      for (int a = 0; a < 9; a++) rd(a[3:0], (a < 8) ? m[a] : 8'h00);
      for (int a = 0; a < 8; a++) wr(a[3:0], 8'h00);
   endtask : t_reserved
   // two lines in different edge modes, so swapped fields show up
   task automatic t_edges;
      logic [1:0] m1;
      logic [1:0] m0;
      wr(LINE_EN_OFS, 8'h03);
      for (int i = 1; i < 4; i++) begin
         m1 = i[1:0];
         m0 = 2'((i % 3) + 1);
         wr(SENSE_OFS, {4'h0, m1, m0});
         wr(LINE_FLAG_OFS, 8'h03);
         @(posedge core_clk_i) {line1, line0} <= 2'h0;
         settle(3);
         rd(LINE_FLAG_OFS, {6'h00, hit(m1, 1), hit(m0, 1)});
         `CHK(irq, 5'h00)
         wr(LINE_FLAG_OFS, 8'h03);
         rd(LINE_FLAG_OFS, 8'h00);
         @(posedge core_clk_i) {line1, line0} <= 2'h3;
         settle(3);
         rd(LINE_FLAG_OFS, {6'h00, hit(m1, 0), hit(m0, 0)});
      end
      wr(LINE_FLAG_OFS, 8'h03);
   endtask : t_edges
   // low level held for many cycles, as a source must
   task automatic t_level;
      wr(SENSE_OFS, 8'h00);
      @(posedge core_clk_i) begin
         gie <= 1'b1;
         line0 <= 1'b0;
      end
      settle(3);
      `CHK(irq.line_zero, 1'b1)
      `CHK(irq.line_one, 1'b0)
      rd(LINE_FLAG_OFS, 8'h00);
      `CHK(irq.line_zero, 1'b1)
      @(posedge core_clk_i) gie <= 1'b0;
      settle(3);
      `CHK(irq.line_zero, 1'b0)
      @(posedge core_clk_i) line0 <= 1'b1;
      wr(LINE_EN_OFS, 8'h00);
   endtask : t_level
   // both lines fall at once: lowest vector acked first, each ack clears
   // only its own flag
   task automatic t_line_ack;
      wr(SENSE_OFS, 8'h0A);
      wr(LINE_EN_OFS, 8'h03);
      @(posedge core_clk_i) begin
         gie <= 1'b1;
         ack_on <= 1'b1;
         {line1, line0} <= 2'h0;
      end
      settle(2);
      `CHK(irq, 5'h03)
      settle(3);
      `CHK(irq, 5'h02)
      settle(6);
      `CHK(irq, 5'h00)
      @(posedge core_clk_i) begin
         gie <= 1'b0;
         ack_on <= 1'b0;
         {line1, line0} <= 2'h3;
      end
      rd(LINE_FLAG_OFS, 8'h00);
      wr(LINE_EN_OFS, 8'h00);
   endtask : t_line_ack
   task automatic t_groups;
      int p;
      int k;
      for (int g = 0; g < 3; g++) begin
         p = g * 8 + 3;
         wr(4'(MASK0_OFS + g), 8'h08);
         // masked pin while its group is still disabled
         @(posedge core_clk_i) pins[p] <= ~pins[p];
         settle(3);
         rd(GRP_FLAG_OFS, 8'h00);
         wr(GRP_EN_OFS, 8'(1 << g));
         @(posedge core_clk_i) pins[p + 1] <= ~pins[p + 1];
         settle(3);
         rd(GRP_FLAG_OFS, 8'h00);
         @(posedge core_clk_i) pins[p] <= ~pins[p];
         settle(3);
         `CHK(irq.group, 3'h0)
         rd(GRP_FLAG_OFS, 8'(1 << g));
         wr(GRP_FLAG_OFS, 8'(1 << g));
         rd(GRP_FLAG_OFS, 8'h00);
         @(posedge core_clk_i) begin
            gie <= 1'b1;
            ack_on <= 1'b1;
            pins[p] <= ~pins[p];
         end
         k = 0;
         while (irq.group[g] !== 1'b1 && k < 10) begin
            @(negedge core_clk_i);
            k++;
         end
         `CHK(irq.group, 3'(1 << g))
         settle(4);
         rd(GRP_FLAG_OFS, 8'h00);
         @(posedge core_clk_i) begin
            gie <= 1'b0;
            ack_on <= 1'b0;
         end
         wr(GRP_EN_OFS, 8'h00);
      end
   endtask : t_groups
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #100000;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_reserved();
      t_edges();
      t_level();
      t_line_ack();
      t_groups();
      finish_test();
   end
endmodule : testbench
